/* File: logic/smcb_ctrl.v */
/*
  Mode sequencer, transceiver bias state machine, wake pattern detector
  and Wishbone register slave of a CAN system-basis chip.
  Assumes comparator flags and pins arrive asynchronously and that the
  controller reset pin is open drain with an outside pull-up.
*/
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "smcb_consts.vh"
module smcb_ctrl #(
  parameter [`SMCB_CW-1:0] WK_FILTER_CYC = `SMCB_CYC(`SMCB_T_WK_FILTER_NS),
  parameter [`SMCB_CW-1:0] WK_TIMEOUT_CYC = `SMCB_CYC(`SMCB_T_WK_TIMEOUT_NS),
  parameter [`SMCB_CW-1:0] SILENCE_CYC = `SMCB_CYC(`SMCB_BUS_SILENCE_TIMER_NS),
  parameter [`SMCB_CW-1:0] INACTIVE_CYC = `SMCB_CYC(`SMCB_T_INACTIVE_NS),
  parameter [`SMCB_CW-1:0] RESET_HOLD_CYC = `SMCB_CYC(`SMCB_T_RESET_HOLD_NS)
) (
  input wire I_SYS_CLK,
  input wire I_SYS_RST,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [7:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output wire [31:0] O_WB_DAT,
  output wire O_WB_ACK,
  input wire I_THERMAL_SHUTDOWN_RISING,
  input wire I_THERMAL_SHUTDOWN_FALLING,
  input wire I_REGULATOR_OVERVOLTAGE_RISING,
  input wire I_REGULATOR_OVERVOLTAGE_FALLING,
  input wire I_SUPPLY_UNDERVOLTAGE_FALLING,
  input wire I_SUPPLY_UNDERVOLTAGE_RISING,
  input wire I_BUS_DOMINANT,
  input wire I_TXD,
  input wire I_CONTROLLER_RESET_IN_N,
  output wire O_CONTROLLER_RESET_OUT_N,
  output wire O_CONTROLLER_RESET_OE,
  output wire O_REGULATOR_EN,
  output wire [1:0] O_BIAS_SEL,
  output wire O_DRIVER_EN,
  output wire O_RECEIVER_EN,
  output wire O_BUS_DOMINANT_DRIVE,
  output wire O_RXD,
  output wire O_INACTIVITY_TIMEOUT_FLAG
);

  localparam [2:0] M_RESET = 3'b000;
  localparam [2:0] M_FAILSAFE = 3'b001;
  localparam [2:0] M_STANDBY = 3'b010;
  localparam [2:0] M_NORMAL = 3'b011;
  localparam [2:0] M_SILENT = 3'b100;
  localparam [1:0] X_OFF = 2'b00;
  localparam [1:0] X_INACT = 2'b01;
  localparam [1:0] X_ACT = 2'b10;
  localparam [1:0] X_ACTIVE = 2'b11;
  localparam [1:0] W_IDLE = 2'b00;
  localparam [1:0] W_DOM1 = 2'b01;
  localparam [1:0] W_REC = 2'b10;

  function [`SMCB_CW-1:0] sat_inc;
    input [`SMCB_CW-1:0] v;
    input [`SMCB_CW-1:0] lim;
    begin
      sat_inc = (v >= lim) ? lim : v + 1'b1;
    end
  endfunction

  function [`SMCB_CW-1:0] sat_dec;
    input [`SMCB_CW-1:0] v;
    begin
      sat_dec = (v == {`SMCB_CW{1'b0}}) ? v : v - 1'b1;
    end
  endfunction

  // Only the second stage is ever read by logic.
  reg [8:0] meta_reg;
  reg [8:0] sync_reg;
  always @(posedge I_SYS_CLK) begin
    meta_reg <= {I_CONTROLLER_RESET_IN_N, I_TXD, I_BUS_DOMINANT,
      I_SUPPLY_UNDERVOLTAGE_RISING, I_SUPPLY_UNDERVOLTAGE_FALLING,
      I_REGULATOR_OVERVOLTAGE_FALLING, I_REGULATOR_OVERVOLTAGE_RISING,
      I_THERMAL_SHUTDOWN_FALLING, I_THERMAL_SHUTDOWN_RISING};
    sync_reg <= meta_reg;
  end

  wire tsd_rise = sync_reg[0];
  wire temp_ok = sync_reg[1];
  wire ov_rise = sync_reg[2];
  wire ov_ok = sync_reg[3];
  wire uv_low = sync_reg[4];
  wire sup_ok = sync_reg[5];
  wire bus_dom = sync_reg[6];
  wire txd = sync_reg[7];
  wire rst_pin = sync_reg[8];

  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg [1:0] xcvr_reg;
  reg [1:0] xcvr_next;
  reg [1:0] wk_reg;
  reg [1:0] wk_next;
  reg [1:0] req_reg;
  reg [`SMCB_CW-1:0] dom_cnt_reg;
  reg [`SMCB_CW-1:0] rec_cnt_reg;
  reg [`SMCB_CW-1:0] wk_tmo_reg;
  reg [`SMCB_CW-1:0] sil_cnt_reg;
  reg [`SMCB_CW-1:0] inact_cnt_reg;
  reg [`SMCB_CW-1:0] hold_cnt_reg;
  reg [3:0] guard_reg;
  reg wake_reg;
  reg wake_latch_reg;
  reg tmo_flag_reg;
  reg blk_reg;
  reg ack_reg;
  reg [31:0] rdat_reg;
  reg rst_oe_reg;
  reg reg_en_reg;
  reg [1:0] bias_reg;
  reg drv_en_reg;
  reg rcv_en_reg;
  reg dom_drv_reg;
  reg rxd_reg;

  wire run_mode = (mode_reg == M_NORMAL) || (mode_reg == M_SILENT);
  wire sw_mode = run_mode || (mode_reg == M_STANDBY);
  wire filt_dom = (dom_cnt_reg >= WK_FILTER_CYC);
  wire filt_rec = (rec_cnt_reg >= WK_FILTER_CYC);
  wire fs_entry = tsd_rise || ov_rise;
  wire ext_rst = !rst_pin && (guard_reg == 4'h0);
  wire wb_req = I_WB_CYC && I_WB_STB && !ack_reg;
  // A write lands on the edge at which the master sees ack high.
  wire wb_wr = I_WB_CYC && I_WB_STB && ack_reg && I_WB_WE && I_WB_SEL[0];
  wire wk_enable = !run_mode;

  // Consecutive-cycle counters feeding the wake filters.
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      dom_cnt_reg <= {`SMCB_CW{1'b0}};
      rec_cnt_reg <= {`SMCB_CW{1'b0}};
    end else begin
      dom_cnt_reg <= bus_dom ? sat_inc(dom_cnt_reg, WK_FILTER_CYC)
                             : {`SMCB_CW{1'b0}};
      rec_cnt_reg <= bus_dom ? {`SMCB_CW{1'b0}}
                             : sat_inc(rec_cnt_reg, WK_FILTER_CYC);
    end
  end

  // Other traffic between the phases does not restart the pattern.
  always @* begin
    wk_next = wk_reg;
    case (wk_reg)
      W_IDLE: begin
        if (filt_dom) begin
          wk_next = W_DOM1;
        end
      end
      W_DOM1: begin
        if (wk_tmo_reg == {`SMCB_CW{1'b0}}) begin
          wk_next = W_IDLE;
        end else if (filt_rec) begin
          wk_next = W_REC;
        end
      end
      W_REC: begin
        if (wk_tmo_reg == {`SMCB_CW{1'b0}}) begin
          wk_next = W_IDLE;
        end else if (filt_dom) begin
          wk_next = W_IDLE;
        end
      end
      default: begin
        wk_next = W_IDLE;
      end
    endcase
    if (!wk_enable) begin
      wk_next = W_IDLE;
    end
  end

  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      wk_reg <= W_IDLE;
      wk_tmo_reg <= {`SMCB_CW{1'b0}};
      wake_reg <= 1'b0;
    end else begin
      wk_reg <= wk_next;
      wake_reg <= wk_enable && (wk_reg == W_REC) && (wk_next == W_IDLE)
                  && (wk_tmo_reg != {`SMCB_CW{1'b0}});
      if (wk_reg == W_IDLE) begin
        wk_tmo_reg <= WK_TIMEOUT_CYC;
      end else begin
        wk_tmo_reg <= sat_dec(wk_tmo_reg);
      end
    end
  end

  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      M_RESET: begin
        if (hold_cnt_reg == {`SMCB_CW{1'b0}}) begin
          mode_next = M_STANDBY;
        end
      end
      M_FAILSAFE: begin
        if (temp_ok && ov_ok && wake_reg) begin
          mode_next = M_RESET;
        end
      end
      default: begin
        if (ext_rst) begin
          mode_next = M_RESET;
        end else if (req_reg == `SMCB_REQ_NORMAL) begin
          mode_next = M_NORMAL;
        end else if (req_reg == `SMCB_REQ_SILENT) begin
          mode_next = M_SILENT;
        end else begin
          mode_next = M_STANDBY;
        end
      end
    endcase
    if (fs_entry) begin
      mode_next = M_FAILSAFE;
    end
  end

  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      mode_reg <= M_RESET;
      hold_cnt_reg <= RESET_HOLD_CYC;
      guard_reg <= `SMCB_RST_GUARD;
    end else begin
      mode_reg <= mode_next;
      if (mode_next == M_RESET && mode_reg != M_RESET) begin
        hold_cnt_reg <= RESET_HOLD_CYC;
      end else begin
        hold_cnt_reg <= sat_dec(hold_cnt_reg);
      end
      // The pin needs time to rise after release, so its low level is
      // ignored for a short guard before it can count as an outside pull.
      if (!sw_mode) begin
        guard_reg <= `SMCB_RST_GUARD;
      end else if (guard_reg != 4'h0) begin
        guard_reg <= guard_reg - 4'h1;
      end
    end
  end

  // Inactivity timer; flag is write-one-to-clear and a set wins.
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      inact_cnt_reg <= {`SMCB_CW{1'b0}};
      tmo_flag_reg <= 1'b0;
    end else begin
      if (mode_next == M_STANDBY && mode_reg != M_STANDBY) begin
        inact_cnt_reg <= INACTIVE_CYC;
      end else if (mode_reg == M_STANDBY) begin
        inact_cnt_reg <= sat_dec(inact_cnt_reg);
      end
      if (mode_reg == M_STANDBY &&
          inact_cnt_reg == {{(`SMCB_CW-1){1'b0}}, 1'b1}) begin
        tmo_flag_reg <= 1'b1;
      end else if (wb_wr && I_WB_ADR == `SMCB_ADR_FLAGS &&
                   I_WB_DAT[`SMCB_FLAG_TMO]) begin
        tmo_flag_reg <= 1'b0;
      end
    end
  end

  always @* begin
    xcvr_next = xcvr_reg;
    case (xcvr_reg)
      X_OFF: begin
        if (sup_ok && temp_ok) begin
          xcvr_next = X_INACT;
        end
      end
      X_INACT: begin
        if (run_mode && !uv_low) begin
          xcvr_next = X_ACTIVE;
        end else if (wake_reg) begin
          xcvr_next = X_ACT;
        end
      end
      X_ACT: begin
        if (run_mode && !uv_low) begin
          xcvr_next = X_ACTIVE;
        end else if (sil_cnt_reg == {`SMCB_CW{1'b0}}) begin
          xcvr_next = X_INACT;
        end
      end
      default: begin
        if (!run_mode) begin
          xcvr_next = X_INACT;
        end
      end
    endcase
    if (tsd_rise || uv_low) begin
      xcvr_next = X_OFF;
    end
  end

  // Silence timer runs only while autonomously biased; bus activity
  // restarts it because silence means no dominant seen.
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      xcvr_reg <= X_OFF;
      sil_cnt_reg <= {`SMCB_CW{1'b0}};
    end else begin
      xcvr_reg <= xcvr_next;
      if (xcvr_reg != X_ACT || bus_dom) begin
        sil_cnt_reg <= SILENCE_CYC;
      end else begin
        sil_cnt_reg <= sat_dec(sil_cnt_reg);
      end
    end
  end

  // A transmit input stuck low must not reach the bus after standby.
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      blk_reg <= 1'b0;
    end else if (mode_reg == M_STANDBY &&
                 (mode_next == M_NORMAL || mode_next == M_SILENT)) begin
      blk_reg <= !txd;
    end else if (!run_mode || txd) begin
      blk_reg <= 1'b0;
    end
  end

  // Power-on counts as a wake, so the latch starts set.
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      wake_latch_reg <= 1'b1;
    end else if (!run_mode && (wake_reg || fs_entry || uv_low)) begin
      wake_latch_reg <= 1'b1;
    end else if (run_mode) begin
      wake_latch_reg <= 1'b0;
    end
  end

  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      req_reg <= `SMCB_REQ_STANDBY;
    end else if (!sw_mode) begin
      req_reg <= `SMCB_REQ_STANDBY;
    end else if (wb_wr && I_WB_ADR == `SMCB_ADR_MODE &&
                 I_WB_DAT[1:0] != 2'h3) begin
      req_reg <= I_WB_DAT[1:0];
    end
  end

  // Single-wait slave; unmapped reads return zero and writes are dropped.
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_req;
      if (wb_req) begin
        if (I_WB_ADR == `SMCB_ADR_MODE) begin
          rdat_reg <= {30'h0000_0000, req_reg};
        end else if (I_WB_ADR == `SMCB_ADR_STATUS) begin
          rdat_reg <= {26'h000_0000, blk_reg, xcvr_reg, mode_reg};
        end else if (I_WB_ADR == `SMCB_ADR_FLAGS) begin
          rdat_reg <= {30'h0000_0000, wake_latch_reg, tmo_flag_reg};
        end else begin
          rdat_reg <= 32'h0000_0000;
        end
      end
    end
  end

  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rst_oe_reg <= 1'b1;
      reg_en_reg <= 1'b1;
      bias_reg <= `SMCB_BIAS_FLOAT;
      drv_en_reg <= 1'b0;
      rcv_en_reg <= 1'b0;
      dom_drv_reg <= 1'b0;
      rxd_reg <= 1'b1;
    end else begin
      rst_oe_reg <= (mode_reg == M_RESET) ||
                    (mode_reg == M_FAILSAFE);
      reg_en_reg <= (mode_reg != M_FAILSAFE);
      case (xcvr_reg)
        X_OFF: bias_reg <= `SMCB_BIAS_FLOAT;
        X_INACT: bias_reg <= `SMCB_BIAS_GND;
        X_ACT: bias_reg <= `SMCB_BIAS_2V5;
        default: bias_reg <= `SMCB_BIAS_HALF;
      endcase
      drv_en_reg <= (xcvr_reg == X_ACTIVE) && (mode_reg == M_NORMAL) &&
                    !blk_reg;
      rcv_en_reg <= (xcvr_reg == X_ACTIVE) && run_mode &&
                    !blk_reg;
      dom_drv_reg <= (xcvr_reg == X_ACTIVE) && (mode_reg == M_NORMAL) &&
                     !blk_reg && !txd;
      if (mode_reg == M_FAILSAFE) begin
        rxd_reg <= 1'b1;
      end else if (run_mode) begin
        rxd_reg <= !(rcv_en_reg && bus_dom);
      end else begin
        rxd_reg <= !wake_latch_reg;
      end
    end
  end

  assign O_WB_DAT = rdat_reg;
  assign O_WB_ACK = ack_reg;
  assign O_CONTROLLER_RESET_OUT_N = 1'b0;
  assign O_CONTROLLER_RESET_OE = rst_oe_reg;
  assign O_REGULATOR_EN = reg_en_reg;
  assign O_BIAS_SEL = bias_reg;
  assign O_DRIVER_EN = drv_en_reg;
  assign O_RECEIVER_EN = rcv_en_reg;
  assign O_BUS_DOMINANT_DRIVE = dom_drv_reg;
  assign O_RXD = rxd_reg;
  assign O_INACTIVITY_TIMEOUT_FLAG = tmo_flag_reg;

endmodule // smcb_ctrl
`default_nettype wire

/* File: logic/smcb_consts.vh */
/*
  Constants for the mode, bias and wake sequencer.
  Assumes a 10 MHz system clock and a classic Wishbone register bus.
*/
// Contract
// - Reset mode holds controller reset low, transceiver off, bus grounded.
// - Reset mode watches for wake pattern, then biases bus to 2.5 V.
// - Power-on or external pull on controller reset enters reset mode.
// - Leaving fail-safe after faults clear goes to reset mode.
// - Fail-safe turns regulator off, holds reset low, transceiver off; code only disables driver and receiver, bias still follows wake.
// - Thermal or regulator overvoltage rising flag enters fail-safe.
// - Fail-safe exits only with temperature, voltage good and wake.
// - Inactivity expiry sets timeout flag and stays in standby.
// - Thermal rising or supply undervoltage puts transceiver off.
// - Off goes autonomous inactive when supply and temperature good.
// - Standby puts transceiver autonomous inactive, bus grounded.
// - Wake or normal without undervoltage leaves autonomous inactive.
// - Bus silence expiry returns autonomous active to inactive.
// - Normal without undervoltage makes transceiver active.
// - Low transmit input when leaving standby blocks the transceiver.
// - Silent disables driver, ignores transmit, receiver works.
// - Dominant only in normal with transmit low, else recessive.
// - Normal and silent receive output follows bus state.
// - Standby receive output high unless a wake persists.
// - Standby entry starts inactivity timer; expiry sets timeout flag.
// - Wake pattern is filtered dominant, recessive, dominant.
// - Standby receive output latches low on wake, fault or power-on.
`ifndef SMCB_CONSTS_VH
`define SMCB_CONSTS_VH
`define SMCB_CLK_PERIOD_NS 100
`define SMCB_CYC(ns) (((ns) + `SMCB_CLK_PERIOD_NS - 1) / `SMCB_CLK_PERIOD_NS)
`define SMCB_T_WK_FILTER_NS 1000
`define SMCB_T_WK_TIMEOUT_NS 1000000
`define SMCB_BUS_SILENCE_TIMER_NS 1000000
`define SMCB_T_INACTIVE_NS 10000000
`define SMCB_T_RESET_HOLD_NS 20000
`define SMCB_CW 24
`define SMCB_RST_GUARD 4'h8
`define SMCB_ADR_MODE 8'h00
`define SMCB_ADR_STATUS 8'h04
`define SMCB_ADR_FLAGS 8'h08
`define SMCB_REQ_STANDBY 2'h0
`define SMCB_REQ_NORMAL 2'h1
`define SMCB_REQ_SILENT 2'h2
`define SMCB_BIAS_FLOAT 2'h0
`define SMCB_BIAS_GND 2'h1
`define SMCB_BIAS_2V5 2'h2
`define SMCB_BIAS_HALF 2'h3
`define SMCB_FLAG_TMO 0
`define SMCB_FLAG_WAKE 1
`endif

/* File: tb/smcb_props.sv */
/*
  Port checker for smcb_ctrl.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smcb_consts.vh"
module smcb_props #(
  parameter int SILENCE_CYC = 50
) (
  input wire I_SYS_CLK,
  input wire I_SYS_RST,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire O_WB_ACK,
  input wire I_THERMAL_SHUTDOWN_RISING,
  input wire I_REGULATOR_OVERVOLTAGE_RISING,
  input wire I_SUPPLY_UNDERVOLTAGE_FALLING,
  input wire I_BUS_DOMINANT,
  input wire O_CONTROLLER_RESET_OE,
  input wire O_REGULATOR_EN,
  input wire [1:0] O_BIAS_SEL,
  input wire O_DRIVER_EN,
  input wire O_RECEIVER_EN,
  input wire O_BUS_DOMINANT_DRIVE,
  input wire O_RXD,
  input wire O_INACTIVITY_TIMEOUT_FLAG
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic [15:0] quiet_reg;
  sequence hot_s; I_THERMAL_SHUTDOWN_RISING [*6]; endsequence
  sequence ov_s; I_REGULATOR_OVERVOLTAGE_RISING [*6]; endsequence
  sequence req_s; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
  // Dominant bus traffic legitimately restarts the silence count.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST || O_BIAS_SEL != `SMCB_BIAS_2V5 || I_BUS_DOMINANT)
      quiet_reg <= 16'h0;
    else
      quiet_reg <= quiet_reg + 16'h1;
  end
  fs_hot_a: assert property (hot_s |-> !O_REGULATOR_EN)
    else $error("heat did not stop the regulator");
  fs_ov_a: assert property (ov_s |-> O_CONTROLLER_RESET_OE)
    else $error("overvoltage did not hold reset");
  fs_quiet_a: assert property (!O_REGULATOR_EN |->
    O_CONTROLLER_RESET_OE && !O_DRIVER_EN && !O_RECEIVER_EN)
    else $error("fail-safe outputs wrong");
  uv_off_a: assert property (I_SUPPLY_UNDERVOLTAGE_FALLING [*6] |->
    O_BIAS_SEL == `SMCB_BIAS_FLOAT && !O_DRIVER_EN)
    else $error("undervoltage left transceiver on");
  dom_drv_a: assert property (O_BUS_DOMINANT_DRIVE |->
    O_DRIVER_EN && O_BIAS_SEL == `SMCB_BIAS_HALF)
    else $error("dominant driven outside active");
  rcv_bias_a: assert property (O_RECEIVER_EN |->
    O_BIAS_SEL == `SMCB_BIAS_HALF && O_REGULATOR_EN)
    else $error("receiver on without regulator bias");
  rx_follow_a: assert property (
    (O_RECEIVER_EN && I_BUS_DOMINANT) [*5] |-> !O_RXD)
    else $error("receive output missed dominant");
  por_state_a: assert property ($fell(I_SYS_RST) |-> O_CONTROLLER_RESET_OE
    && O_REGULATOR_EN && !O_DRIVER_EN && O_RXD)
    else $error("reset mode not entered");
  tmo_standby_a: assert property ($rose(O_INACTIVITY_TIMEOUT_FLAG) |->
    !O_CONTROLLER_RESET_OE && !O_DRIVER_EN && O_REGULATOR_EN)
    else $error("timeout flag outside standby");
  silence_end_a: assert property (quiet_reg <= SILENCE_CYC + 8)
    else $error("bus stayed biased past silence time");
  ack_once_a: assert property (req_s |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("bus answer not one cycle");
endmodule // smcb_props
`default_nettype wire

/* File: tb/smcb_mcu_model.sv */
/*
  Controller-side model: open-drain reset pin with pull-up and TXD.
  Assumes the bench steps its commands on rising clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module smcb_mcu_model (
  input wire logic i_reset_oe,
  input wire logic i_reset_val,
  input wire logic i_pull_low,
  input wire logic i_tx_low,
  output logic o_reset_pin,
  output logic o_txd
);
  // The pull-up wins only when nobody sinks the line.
  assign o_reset_pin = !(i_pull_low || (i_reset_oe && !i_reset_val));
  assign o_txd = !i_tx_low;
endmodule // smcb_mcu_model
`default_nettype wire

/* File: tb/smcb_tb.sv */
/*
  Self-checking bench for smcb_ctrl with the controller model.
  Assumes smcb_consts.vh on the include path; timers are shortened.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smcb_consts.vh"
module tb;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic ths_r = 1'b0, ths_f = 1'b1, ov_r = 1'b0, ov_f = 1'b1;
  logic uv_f = 1'b0, uv_r = 1'b1, bus_dom = 1'b0, tx_low = 1'b0;
  logic pull = 1'b0, ack, pin, txd, rnout, oe, reg_en, drv, rcv, dom;
  logic rxd, tmo;
  logic [1:0] bias;
  int err_total = 0;
  int checks = 0;
  always #50 clk = ~clk;
  // Short timers: filter 4, wake window 200, silence 50, idle 100, hold 60.
  smcb_ctrl #(.WK_FILTER_CYC(24'h4), .WK_TIMEOUT_CYC(24'hc8),
    .SILENCE_CYC(24'h32), .INACTIVE_CYC(24'h64), .RESET_HOLD_CYC(24'h3c))
  dut_u (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_THERMAL_SHUTDOWN_RISING(ths_r),
    .I_THERMAL_SHUTDOWN_FALLING(ths_f),
    .I_REGULATOR_OVERVOLTAGE_RISING(ov_r),
    .I_REGULATOR_OVERVOLTAGE_FALLING(ov_f),
    .I_SUPPLY_UNDERVOLTAGE_FALLING(uv_f),
    .I_SUPPLY_UNDERVOLTAGE_RISING(uv_r), .I_BUS_DOMINANT(bus_dom),
    .I_TXD(txd), .I_CONTROLLER_RESET_IN_N(pin),
    .O_CONTROLLER_RESET_OUT_N(rnout), .O_CONTROLLER_RESET_OE(oe),
    .O_REGULATOR_EN(reg_en), .O_BIAS_SEL(bias), .O_DRIVER_EN(drv),
    .O_RECEIVER_EN(rcv), .O_BUS_DOMINANT_DRIVE(dom), .O_RXD(rxd),
    .O_INACTIVITY_TIMEOUT_FLAG(tmo));
  smcb_mcu_model mcu_u (.i_reset_oe(oe), .i_reset_val(rnout),
    .i_pull_low(pull), .i_tx_low(tx_low), .o_reset_pin(pin), .o_txd(txd));
  task automatic finish_test;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return oe === 1'b0;
      1: return bias === `SMCB_BIAS_2V5;
      2: return bias === `SMCB_BIAS_GND;
      3: return tmo === 1'b1;
      4: return oe === 1'b1;
      default: return reg_en === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    while (!cond(k) && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      finish_test();
    end
  endtask
  // Holds the request until ack is sampled, then releases it.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic wake_pat(input int n);
    for (int i = 0; i < 3; i++) begin
      bus_dom <= (i != 1);
      cyc_n(n);
    end
    bus_dom <= 1'b0;
  endtask
  task automatic s_reset;
    cyc_n(7);
    chk({rnout, oe, reg_en, drv, rcv}, 5'h0c);
    chk(bias, `SMCB_BIAS_GND);
    wait_for(0, 100);
    cyc_n(2);
    chk(bias, `SMCB_BIAS_GND);
    chk(rxd, 1'b0);
  endtask
  task automatic s_timeout;
    wait_for(3, 200);
    wb(1'b0, `SMCB_ADR_FLAGS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    chk(oe, 1'b0);
    wb(1'b1, `SMCB_ADR_FLAGS, 32'h1);
    wb(1'b0, `SMCB_ADR_FLAGS, 32'h0);
    chk(rd & 32'h1, 32'h0);
  endtask
  task automatic s_normal;
    wb(1'b1, `SMCB_ADR_MODE, 32'h1);
    cyc_n(6);
    chk({drv, rcv, bias}, 4'hf);
    tx_low <= 1'b1;
    cyc_n(6);
    chk(dom, 1'b1);
    tx_low <= 1'b0;
    bus_dom <= 1'b1;
    cyc_n(6);
    chk({dom, rxd}, 2'h0);
    bus_dom <= 1'b0;
    cyc_n(6);
    chk(rxd, 1'b1);
    wb(1'b1, `SMCB_ADR_MODE, 32'h2);
    tx_low <= 1'b1;
    cyc_n(6);
    chk({drv, rcv, dom, bias}, 5'h0b);
    tx_low <= 1'b0;
    wb(1'b1, `SMCB_ADR_MODE, 32'h3);
    wb(1'b0, `SMCB_ADR_MODE, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, `SMCB_ADR_MODE, 32'h0);
    cyc_n(6);
    chk({rxd, bias}, 3'h5);
  endtask
  task automatic s_wake;
    wake_pat(2);
    cyc_n(8);
    chk({rxd, bias}, 3'h5);
    wake_pat(6);
    wait_for(1, 20);
    chk(rxd, 1'b0);
    wait_for(2, 100);
  endtask
  task automatic s_txblock;
    tx_low <= 1'b1;
    wb(1'b1, `SMCB_ADR_MODE, 32'h1);
    cyc_n(6);
    chk({drv, rcv}, 2'h0);
    wb(1'b0, `SMCB_ADR_STATUS, 32'h0);
    chk(rd[5], 1'b1);
    tx_low <= 1'b0;
    cyc_n(6);
    chk(drv, 1'b1);
    wb(1'b1, `SMCB_ADR_MODE, 32'h0);
    cyc_n(12);
  endtask
  task automatic s_extrst;
    pull <= 1'b1;
    cyc_n(3);
    pull <= 1'b0;
    wait_for(4, 20);
    wake_pat(6);
    wait_for(1, 20);
    chk({oe, rxd}, 2'h2);
    wait_for(0, 100);
  endtask
  task automatic s_fault;
    uv_f <= 1'b1;
    uv_r <= 1'b0;
    cyc_n(6);
    chk(bias, `SMCB_BIAS_FLOAT);
    uv_f <= 1'b0;
    uv_r <= 1'b1;
    cyc_n(6);
    chk(bias, `SMCB_BIAS_GND);
    for (int k = 0; k < 2; k++) begin
      ths_r <= (k == 0);
      ths_f <= (k != 0);
      ov_r <= (k == 1);
      ov_f <= (k != 1);
      cyc_n(6);
      chk({reg_en, oe, rxd}, 3'h3);
      wb(1'b0, `SMCB_ADR_STATUS, 32'h0);
      chk(rd & 32'h7, 32'h1);
      ths_r <= 1'b0;
      ths_f <= 1'b1;
      ov_r <= 1'b0;
      ov_f <= 1'b1;
      cyc_n(20);
      chk(reg_en, 1'b0);
      wake_pat(6);
      wait_for(5, 40);
      chk(oe, 1'b1);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_timeout();
    s_normal();
    s_wake();
    s_txblock();
    s_extrst();
    s_fault();
    finish_test();
  end
endmodule // tb
bind smcb_ctrl smcb_props #(.SILENCE_CYC(SILENCE_CYC)) chk_u (
  .I_SYS_CLK(I_SYS_CLK),
  .I_SYS_RST(I_SYS_RST),
  .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB),
  .O_WB_ACK(O_WB_ACK),
  .I_THERMAL_SHUTDOWN_RISING(I_THERMAL_SHUTDOWN_RISING),
  .I_REGULATOR_OVERVOLTAGE_RISING(I_REGULATOR_OVERVOLTAGE_RISING),
  .I_SUPPLY_UNDERVOLTAGE_FALLING(I_SUPPLY_UNDERVOLTAGE_FALLING),
  .I_BUS_DOMINANT(I_BUS_DOMINANT),
  .O_CONTROLLER_RESET_OE(O_CONTROLLER_RESET_OE),
  .O_REGULATOR_EN(O_REGULATOR_EN),
  .O_BIAS_SEL(O_BIAS_SEL),
  .O_DRIVER_EN(O_DRIVER_EN),
  .O_RECEIVER_EN(O_RECEIVER_EN),
  .O_BUS_DOMINANT_DRIVE(O_BUS_DOMINANT_DRIVE),
  .O_RXD(O_RXD),
  .O_INACTIVITY_TIMEOUT_FLAG(O_INACTIVITY_TIMEOUT_FLAG));
`default_nettype wire
